// *** logic/cds_clock_strobes.sv ***
// Clock divider, speed select, fetch select and external memory strobes
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module cds_clock_strobes #(
    parameter bit LARGE_CODE = 1'b0
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic        crystal_in,
    input  wire logic        external_fetch_enable_n,
    output logic             ale,
    output logic             code_read_strobe_n,
    // Core side
    input  wire logic [15:0] pc,
    input  wire logic        data_access,
    input  wire logic        security_level1,
    output logic             state_tick,
    output logic             machine_cycle,
    output logic             standard_speed,
    output logic             ext_fetch
);
    logic                xs1;
    logic                xs2;
    logic                xs3;
    logic                es1;
    logic                es2;
    logic                xtal_rise;
    logic                div2;
    logic                div_rise;
    logic                tick;
    logic                double_speed_bit;
    logic                speed_active;
    logic                ale_disable;
    logic                pin_latched;
    logic                pin_captured;
    logic [1:0]          pin_fill;
    logic                pin_eff;
    logic                data_q;
    logic                next_ext;
    logic                next_ale;
    logic                next_code_strobe;
    logic                setup;
    logic [31:0]         next_rdata;
    logic                next_err;
    cds_pkg::cds_state_e state;

    function automatic logic [31:0] bit_word(input logic b, input int pos);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[pos] = b;
        return w;
    endfunction

    cds_mc_seq u_seq (
        .pclk       (pclk),
        .presetn    (presetn),
        .state_tick (tick),
        .state      (state)
    );

    // Pins are asynchronous to pclk; crystal must run at most pclk/4
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xs1 <= 1'b0;
            xs2 <= 1'b0;
            xs3 <= 1'b0;
            es1 <= 1'b1;
            es2 <= 1'b1;
        end else begin
            xs1 <= crystal_in;
            xs2 <= xs1;
            xs3 <= xs2;
            es1 <= external_fetch_enable_n;
            es2 <= es1;
        end
    end

    assign xtal_rise = xs2 & ~xs3;
    assign div_rise  = xtal_rise & ~div2;
    // Halver feeds the phase generator unless double speed bypasses it
    assign tick      = speed_active ? xtal_rise : div_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div2 <= 1'b0;
        end else if (xtal_rise) begin
            div2 <= ~div2;
        end
    end

    // New speed only on a halved rising edge, which is also a state boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_active <= cds_pkg::SPEED_RST;
        end else if (div_rise) begin
            speed_active <= double_speed_bit;
        end
    end

    // Pin level is latched once the synchroniser holds a real sample, not its reset value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_fill     <= 2'h0;
            pin_latched  <= 1'b1;
            pin_captured <= 1'b0;
        end else begin
            pin_fill <= {pin_fill[0], 1'b1};
            if (pin_fill[1] && !pin_captured) begin
                pin_latched  <= es2;
                pin_captured <= 1'b1;
            end
        end
    end

    assign pin_eff = (security_level1 && pin_captured) ? pin_latched : es2;

    always_comb begin
        // Pin low forces external fetch over the whole range
        if (pin_eff) begin
            next_ext = pc > (LARGE_CODE ? cds_pkg::TOP_LARGE : cds_pkg::TOP_SMALL);
        end else begin
            next_ext = 1'b1;
        end
    end

    // Fetch source and data-access flag hold for a whole machine cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_fetch     <= 1'b0;
            data_q        <= 1'b0;
            machine_cycle <= 1'b0;
        end else begin
            machine_cycle <= tick && state == cds_pkg::CDS_S6;
            if (tick && state == cds_pkg::CDS_S6) begin
                ext_fetch <= next_ext;
                data_q    <= data_access;
            end
        end
    end

    always_comb begin
        next_ale = 1'b0;
        if (state == cds_pkg::CDS_S4) begin
            next_ale = 1'b1;
        end else if (state == cds_pkg::CDS_S1) begin
            next_ale = ~data_q;
        end
        if (ale_disable && !ext_fetch && !data_q) begin
            next_ale = 1'b0;
        end
        next_code_strobe = (state == cds_pkg::CDS_S2 || state == cds_pkg::CDS_S5)
                           && ext_fetch && !data_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale                <= 1'b0;
            code_read_strobe_n <= 1'b1;
            state_tick         <= 1'b0;
            standard_speed     <= 1'b1;
        end else begin
            ale                <= next_ale;
            code_read_strobe_n <= ~next_code_strobe;
            state_tick         <= tick;
            standard_speed     <= ~speed_active;
        end
    end

    // APB: zero wait states, answer prepared in the setup cycle
    assign setup = psel & ~penable;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        unique case (paddr)
            cds_pkg::CLK_CTRL_ADDR: next_rdata = bit_word(double_speed_bit, cds_pkg::SPEED_BIT);
            cds_pkg::AUX_CTRL_ADDR: next_rdata = bit_word(ale_disable, cds_pkg::ALE_OFF_BIT);
            cds_pkg::STATUS_ADDR: begin
                next_rdata = bit_word(speed_active, cds_pkg::ST_SPEED_BIT)
                           | bit_word(ext_fetch, cds_pkg::ST_EXT_BIT)
                           | bit_word(pin_eff, cds_pkg::ST_PIN_BIT)
                           | bit_word(data_q, cds_pkg::ST_DATA_BIT);
            end
            default: next_err = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= next_err;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            double_speed_bit <= cds_pkg::SPEED_RST;
            ale_disable      <= cds_pkg::ALE_OFF_RST;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == cds_pkg::CLK_CTRL_ADDR) begin
                double_speed_bit <= pwdata[cds_pkg::SPEED_BIT];
            end
            if (paddr == cds_pkg::AUX_CTRL_ADDR) begin
                ale_disable <= pwdata[cds_pkg::ALE_OFF_BIT];
            end
        end
    end

    // Helper counters for the checks below
    logic       ale_q;
    logic       strobe_n_q;
    logic [3:0] ale_gap;
    logic       ale_seen;
    logic [2:0] strobe_falls;
    logic       mc_seen;
    logic [1:0] rise_gap;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale_q      <= 1'b0;
            strobe_n_q <= 1'b1;
        end else begin
            ale_q      <= ale;
            strobe_n_q <= code_read_strobe_n;
        end
    end

    // Reset is standard speed, so the first tick is credited one skipped rise;
    // a silenced strobe train restarts the spacing check at its next pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale_gap      <= 4'h0;
            ale_seen     <= 1'b0;
            strobe_falls <= 3'h0;
            mc_seen      <= 1'b0;
            rise_gap     <= 2'h1;
        end else begin
            if (ale && !ale_q) begin
                ale_gap  <= 4'h0;
                ale_seen <= 1'b1;
            end else if (tick && ale_gap != 4'hF) begin
                ale_gap <= ale_gap + 4'h1;
            end
            if (ale_disable) begin
                ale_seen <= 1'b0;
            end
            if (machine_cycle) begin
                strobe_falls <= 3'h0;
                mc_seen      <= 1'b1;
            end else if (!code_read_strobe_n && strobe_n_q) begin
                strobe_falls <= strobe_falls + 3'h1;
            end
            if (tick) begin
                rise_gap <= 2'h0;
            end else if (xtal_rise && rise_gap != 2'h3) begin
                rise_gap <= rise_gap + 2'h1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cycle_ext_code;
        machine_cycle && mc_seen && $past(ext_fetch) && !$past(data_q);
    endsequence

    a_speed_on_halved: assert property ($changed(speed_active) |-> $past(div_rise))
        else $error("speed changed off a halved clock edge");
    a_speed_from_bit: assert property ($rose(speed_active) |-> $past(double_speed_bit))
        else $error("double speed entered without the speed bit");
    a_tick_spacing: assert property (tick |-> rise_gap == (speed_active ? 2'h0 : 2'h1))
        else $error("wrong crystal periods between state ticks");
    a_ale_gap_states: assert property (
        ale && !ale_q && ale_seen && !ale_disable |-> ale_gap == 4'(cds_pkg::ALE_GAP)
                                               || ale_gap == 4'(cds_pkg::ALE_GAP_SKIP))
        else $error("address strobe spacing wrong");
    a_ale_off_internal: assert property (
        ale |-> $past(!ale_disable || ext_fetch || data_q))
        else $error("address strobe during silenced internal fetch");
    a_strobe_twice_cycle: assert property (s_cycle_ext_code |-> strobe_falls == 3'h2)
        else $error("code read strobe not twice in external cycle");
    a_strobe_data_skip: assert property (
        machine_cycle && mc_seen && $past(data_q) |-> strobe_falls == 3'h0)
        else $error("code read strobe during data access cycle");
    a_strobe_internal: assert property (!code_read_strobe_n |-> $past(ext_fetch))
        else $error("code read strobe on internal fetch");
    a_pin_held: assert property (pin_captured ##1 pin_captured |-> $stable(pin_latched))
        else $error("latched access level changed after reset");
    a_ext_low_pin: assert property (
        tick && state == cds_pkg::CDS_S6 && !pin_eff |=> ext_fetch)
        else $error("internal fetch with access pin low");
    a_mc_after_six: assert property (machine_cycle |-> state == cds_pkg::CDS_S1 ##1 !machine_cycle)
        else $error("machine cycle pulse misplaced");
endmodule

// *** logic/cds_mc_seq.sv ***
// Machine-cycle state sequencer driven by core state ticks
`timescale 1ns/1ns
module cds_mc_seq (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Advance request
    input  wire logic              state_tick,
    // Sequencer state
    output cds_pkg::cds_state_e    state
);
    // Reset parks in the last state so the first tick opens a fresh cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= cds_pkg::CDS_S6;
        end else if (state_tick) begin
            unique case (state)
                cds_pkg::CDS_S1: state <= cds_pkg::CDS_S2;
                cds_pkg::CDS_S2: state <= cds_pkg::CDS_S3;
                cds_pkg::CDS_S3: state <= cds_pkg::CDS_S4;
                cds_pkg::CDS_S4: state <= cds_pkg::CDS_S5;
                cds_pkg::CDS_S5: state <= cds_pkg::CDS_S6;
                cds_pkg::CDS_S6: state <= cds_pkg::CDS_S1;
                default:         state <= cds_pkg::CDS_S6;
            endcase
        end
    end
endmodule

// *** logic/cds_pkg.sv ***
// Constants and types shared by the clock divider and bus strobe block
package cds_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    // Register indices; the byte address is four times the index
    localparam logic [7:0]  CLK_CTRL_IDX    = 8'h8F;
    localparam logic [7:0]  AUX_CTRL_IDX    = 8'h90;
    localparam logic [7:0]  STATUS_IDX      = 8'h91;
    localparam logic [11:0] CLK_CTRL_ADDR   = {2'h0, CLK_CTRL_IDX, 2'h0};
    localparam logic [11:0] AUX_CTRL_ADDR   = {2'h0, AUX_CTRL_IDX, 2'h0};
    localparam logic [11:0] STATUS_ADDR     = {2'h0, STATUS_IDX, 2'h0};
    // Field positions and reset values
    localparam int          SPEED_BIT       = 0;
    localparam int          ALE_OFF_BIT     = 0;
    localparam int          ST_SPEED_BIT    = 0;
    localparam int          ST_EXT_BIT      = 1;
    localparam int          ST_PIN_BIT      = 2;
    localparam int          ST_DATA_BIT     = 3;
    localparam logic        SPEED_RST       = 1'b0;
    localparam logic        ALE_OFF_RST     = 1'b0;
    // Top of the on-chip code range for each variant
    localparam logic [15:0] TOP_SMALL       = 16'h3FFF;
    localparam logic [15:0] TOP_LARGE       = 16'h7FFF;
    // Clock periods per machine cycle in each mode
    localparam int          PERIODS_NORMAL  = 12;
    localparam int          PERIODS_DOUBLE  = 6;
    localparam int          STATES_PER_MC   = 6;
    // Address strobe spacing in states, and with one pulse dropped
    localparam int          ALE_GAP         = STATES_PER_MC / 2;
    localparam int          ALE_GAP_SKIP    = STATES_PER_MC;
    localparam int          PCLK_MHZ        = 20;

    // Six machine-cycle states, one-hot
    typedef enum logic [5:0] {
        CDS_S1 = 6'h01,
        CDS_S2 = 6'h02,
        CDS_S3 = 6'h04,
        CDS_S4 = 6'h08,
        CDS_S5 = 6'h10,
        CDS_S6 = 6'h20
    } cds_state_e;
endpackage

// *** sim/cds_ext_mem_model.sv ***
// Behavioural external memory that follows the address and code read strobes
`timescale 1ns/1ns
module cds_ext_mem_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Strobes from the device
    input  wire logic ale,
    input  wire logic code_read_strobe_n,
    // Activity counts seen by the memory
    output int        ale_count,
    output int        code_read_count
);
    logic ale_q;
    logic strobe_n_q;

    // Each rising address strobe is one low address capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale_q     <= 1'b0;
            ale_count <= 0;
        end else begin
            ale_q <= ale;
            if (ale && !ale_q) begin
                ale_count <= ale_count + 1;
            end
        end
    end

    // Each falling code strobe is one external code read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_n_q      <= 1'b1;
            code_read_count <= 0;
        end else begin
            strobe_n_q <= code_read_strobe_n;
            if (!code_read_strobe_n && strobe_n_q) begin
                code_read_count <= code_read_count + 1;
            end
        end
    end
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the clock divider and bus strobe block
`timescale 1ns/1ns
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        crystal_in = 1'b0;
    logic        external_fetch_enable_n, ale, code_read_strobe_n, err;
    logic [15:0] pc;
    logic        data_access, security_level1, state_tick, machine_cycle;
    logic        standard_speed, ext_fetch;
    logic [1:0]  xtal_div = 2'h0;
    int          err_count, checks_done, ale_count, code_read_count, mc_ale, mc_code, mc_len;
    int          mc_tick, tick_count = 0;

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end

    cds_clock_strobes #(.LARGE_CODE(1'b0)) cds_clock_strobes_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystal_in(crystal_in), .external_fetch_enable_n(external_fetch_enable_n),
        .ale(ale), .code_read_strobe_n(code_read_strobe_n), .pc(pc),
        .data_access(data_access), .security_level1(security_level1),
        .state_tick(state_tick), .machine_cycle(machine_cycle),
        .standard_speed(standard_speed), .ext_fetch(ext_fetch));

    cds_ext_mem_model cds_ext_mem_model_inst (
        .pclk(pclk), .presetn(presetn), .ale(ale), .code_read_strobe_n(code_read_strobe_n),
        .ale_count(ale_count), .code_read_count(code_read_count));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Crystal at a quarter of pclk keeps highs and lows two pclk long
    always @(posedge pclk) begin
        xtal_div   <= xtal_div + 2'h1;
        crystal_in <= xtal_div[1];
    end

    // State ticks counted on the same edges as the memory model counts strobes
    always @(posedge pclk) begin
        if (state_tick === 1'b1) begin
            tick_count <= tick_count + 1;
        end
    end

    task automatic end_sim();
        $display("Errors %0d, checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_count++;
            $display("CHECK FAILED t=%0t no bus answer", $time);
            end_sim();
        end
    endtask

    task automatic wait_mc();
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (machine_cycle !== 1'b1 && n < 200);
        if (n >= 200) begin
            err_count++;
            $display("CHECK FAILED t=%0t no machine cycle", $time);
            end_sim();
        end
    endtask

    // Counts strobes over one whole machine cycle; also ends a one-cycle data request
    task automatic measure();
        int  a0, c0, k0;
        time t0;
        wait_mc();
        a0 = ale_count;
        c0 = code_read_count;
        k0 = tick_count;
        t0 = $time;
        @(posedge pclk);
        data_access <= 1'b0;
        wait_mc();
        mc_ale  = ale_count - a0;
        mc_code = code_read_count - c0;
        mc_len  = int'(($time - t0) / 50);
        mc_tick = tick_count - k0;
    endtask

    task automatic settle_and_measure();
        wait_mc();
        wait_mc();
        measure();
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic t_regs();
        `CHK(standard_speed, 1'b1)
        apb(1'b0, cds_pkg::CLK_CTRL_ADDR, 32'h0);
        `CHK(rd, 32'h0000_0000)
        `CHK(err, 1'b0)
        apb(1'b1, cds_pkg::CLK_CTRL_ADDR, 32'hFFFF_FFFE);
        apb(1'b0, cds_pkg::CLK_CTRL_ADDR, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, cds_pkg::AUX_CTRL_ADDR, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, 12'h300, 32'h0);
        `CHK(err, 1'b1)
    endtask

    task automatic t_ext();
        external_fetch_enable_n <= 1'b0;
        settle_and_measure();
        `CHK(mc_len, 48)
        `CHK(mc_tick, 6)
        `CHK(mc_ale, 2)
        `CHK(mc_code, 2)
        `CHK(ext_fetch, 1'b1)
        @(posedge pclk);
        data_access <= 1'b1;
        measure();
        `CHK(mc_ale, 1)
        `CHK(mc_code, 0)
        measure();
        `CHK(mc_code, 2)
    endtask

    task automatic t_int();
        external_fetch_enable_n <= 1'b1;
        pc                      <= cds_pkg::TOP_SMALL;
        settle_and_measure();
        `CHK(mc_code, 0)
        `CHK(mc_ale, 2)
        apb(1'b1, cds_pkg::AUX_CTRL_ADDR, 32'h1);
        settle_and_measure();
        `CHK(mc_ale, 0)
        apb(1'b1, cds_pkg::AUX_CTRL_ADDR, 32'h0);
        pc <= cds_pkg::TOP_SMALL + 16'h0001;
        settle_and_measure();
        `CHK(mc_code, 2)
        `CHK(ext_fetch, 1'b1)
        pc <= 16'h0000;
    endtask

    task automatic t_x2();
        apb(1'b1, cds_pkg::CLK_CTRL_ADDR, 32'h1);
        apb(1'b0, cds_pkg::CLK_CTRL_ADDR, 32'h0);
        `CHK(rd, 32'h0000_0001)
        settle_and_measure();
        `CHK(mc_len, 24)
        `CHK(mc_tick, 6)
        `CHK(mc_ale, 2)
        `CHK(standard_speed, 1'b0)
        apb(1'b0, cds_pkg::STATUS_ADDR, 32'h0);
        `CHK(rd, 32'h0000_0005)
        apb(1'b1, cds_pkg::CLK_CTRL_ADDR, 32'h0);
        settle_and_measure();
        `CHK(mc_len, 48)
    endtask

    // The secured part keeps the pin level it saw at reset, whichever way the pin moves later
    task automatic t_sec();
        security_level1         <= 1'b1;
        external_fetch_enable_n <= 1'b1;
        do_reset();
        @(posedge pclk);
        @(posedge pclk);
        external_fetch_enable_n <= 1'b0;
        settle_and_measure();
        `CHK(mc_code, 0)
        `CHK(standard_speed, 1'b1)
        do_reset();
        @(posedge pclk);
        @(posedge pclk);
        external_fetch_enable_n <= 1'b1;
        settle_and_measure();
        `CHK(mc_code, 2)
        `CHK(ext_fetch, 1'b1)
    endtask

    initial begin
        presetn                 = 1'b0;
        psel                    = 1'b0;
        penable                 = 1'b0;
        pwrite                  = 1'b0;
        paddr                   = 12'h000;
        pwdata                  = 32'h0000_0000;
        external_fetch_enable_n = 1'b0;
        pc                      = 16'h0000;
        data_access             = 1'b0;
        security_level1         = 1'b0;
        err_count               = 0;
        checks_done             = 0;
        do_reset();
        t_regs();
        t_ext();
        t_int();
        t_x2();
        t_sec();
        end_sim();
    end
endmodule
